// ---- inc/pves_pkg.sv ----
// Constants for the bus-power event and status register block.
// Assumes a 6-bit register address and byte-wide register data.
package pves_pkg;
	// Bus and data widths
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int NSRC   = 4;
	localparam int LINE_W = 2;

	// Source bit positions, shared by enable, status and latch registers
	localparam int BIT_SESSION_OVER = 3;
	localparam int BIT_SESSION_OK   = 2;
	localparam int BIT_BUS_POWER_OK = 1;
	localparam int BIT_DETACH       = 0;

	// Set and clear aliases sit just above the write address
	localparam logic [ADDR_W-1:0] SET_OFS = 6'h01;
	localparam logic [ADDR_W-1:0] CLR_OFS = 6'h02;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_FALL_EN     = 6'h10;
	localparam logic [ADDR_W-1:0] ADDR_FALL_EN_SET = 6'h11;
	localparam logic [ADDR_W-1:0] ADDR_FALL_EN_CLR = 6'h12;
	localparam logic [ADDR_W-1:0] ADDR_STATUS      = 6'h13;
	localparam logic [ADDR_W-1:0] ADDR_LATCH       = 6'h14;
	localparam logic [ADDR_W-1:0] ADDR_MONITOR     = 6'h15;
	localparam logic [ADDR_W-1:0] ADDR_TEST        = 6'h16;
	localparam logic [ADDR_W-1:0] ADDR_TEST_SET    = 6'h17;
	localparam logic [ADDR_W-1:0] ADDR_TEST_CLR    = 6'h18;
	localparam logic [ADDR_W-1:0] ADDR_HOLE_LO     = 6'h19;
	localparam logic [ADDR_W-1:0] ADDR_HOLE_HI     = 6'h2e;

	// Reset values
	localparam logic [DATA_W-1:0] FALL_EN_RESET = 8'h1f;
	localparam logic [DATA_W-1:0] TEST_RESET    = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_RESET   = 8'h00;
	localparam logic [NSRC-1:0]   LATCH_RESET   = 4'h0;
	localparam logic [NSRC-1:0]   LEVEL_RESET   = 4'h0;

	// Read value of unmapped addresses
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
endpackage : pves_pkg

// ---- inc/pves_bus_if.sv ----
// Write side of the register port, shared by the set/clear registers.
// Assumes one writer (the top) and any number of register targets.
`timescale 1ns/1ps
interface pves_bus_if;
	import pves_pkg::*;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;

	// Top drives the strobe, registers only listen
	modport host   (output wr, output addr, output wdata);
	modport target (input wr, input addr, input wdata);
endinterface : pves_bus_if

// ---- hw/pves_rsc_reg.sv ----
// Byte register with write, bit-set and bit-clear aliases.
// Assumes the bus strobe is one cycle and synchronous to clk.
`timescale 1ns/1ps
module pves_rsc_reg #(
	parameter logic [pves_pkg::ADDR_W-1:0] BASE      = 6'h00,
	parameter logic [pves_pkg::DATA_W-1:0] RESET_VAL = 8'h00
) (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	pves_bus_if.target                       bus,
	output logic      [pves_pkg::DATA_W-1:0] value
);
	import pves_pkg::*;

	logic hit_wr;
	logic hit_set;
	logic hit_clr;

	// Address decode of the three aliases
	assign hit_wr  = bus.wr && (bus.addr == BASE);
	assign hit_set = bus.wr && (bus.addr == BASE + SET_OFS);
	assign hit_clr = bus.wr && (bus.addr == BASE + CLR_OFS);

	// Set ORs in ones, clear removes ones, others untouched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			value <= RESET_VAL;
		end else if (hit_wr) begin
			value <= bus.wdata;
		end else if (hit_set) begin
			value <= value | bus.wdata;
		end else if (hit_clr) begin
			value <= value & ~bus.wdata;
		end
	end

	a_set_or_in: assert property (@(posedge clk) disable iff (!nrst)
		hit_set |=> value == ($past(value) | $past(bus.wdata)))
		else $error("bit-set write did not OR the data in");

	a_clr_and_out: assert property (@(posedge clk) disable iff (!nrst)
		hit_clr |=> value == ($past(value) & ~$past(bus.wdata)))
		else $error("bit-clear write did not clear the written ones");

	a_write_load: assert property (@(posedge clk) disable iff (!nrst)
		hit_wr |=> value == $past(bus.wdata))
		else $error("plain write did not load the byte");

	a_idle_holds: assert property (@(posedge clk) disable iff (!nrst)
		!(hit_wr || hit_set || hit_clr) |=> $stable(value))
		else $error("register changed without an access to it");
endmodule : pves_rsc_reg

// ---- hw/pves_regs.sv ----
// Bus-power event and status registers of a ULPI transceiver front end.
// Assumes source levels and register strobes are synchronous to SYS_CLK.
//
// Contract
// - Enabled falling source edge raises interrupt, RXCMD.
// - All four falling-edge enables set after reset.
// - Enable register read 10h-12h, write/set/clear aliases.
// - Enable bits 3..0: over, ok, power, detach.
// - Status at 13h shows live source levels.
// - Latch bit sets on unmasked source change; here only an enabled fall sets it, rises never do.
// - Reading latch register clears all its bits.
// - Entering low-power mode clears all latch bits.
// - Monitor at 15h shows line state bits.
// - Test byte read 16h-18h, write/set/clear aliases.
// - Test byte resets zero, affects nothing else.
// - Addresses 19h-2Eh unimplemented, accesses change nothing.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module pves_regs (
	input  wire logic                        SYS_CLK,
	input  wire logic                        NRST,
	input  wire logic [pves_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic [pves_pkg::DATA_W-1:0] REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	output logic      [pves_pkg::DATA_W-1:0] REG_RDATA,
	input  wire logic                        SESSION_OVER_LEVEL,
	input  wire logic                        SESSION_OK_LEVEL,
	input  wire logic                        BUS_POWER_OK_LEVEL,
	input  wire logic                        DOWNSTREAM_DETACH_FLAG,
	input  wire logic [pves_pkg::LINE_W-1:0] LINE_STATE,
	input  wire logic                        LOW_POWER,
	output logic                             EVENT_IRQ,
	output logic                             RXCMD_REQ,
	output logic      [pves_pkg::NSRC-1:0]   RXCMD_LEVELS
);
	import pves_pkg::*;

	pves_bus_if bus ();

	logic [DATA_W-1:0] falling_edge_enable;
	logic [DATA_W-1:0] test_byte;
	logic [NSRC-1:0]   source_level;
	logic [NSRC-1:0]   prev_level;
	logic [NSRC-1:0]   fall_en;
	logic [NSRC-1:0]   fall_event;
	logic [NSRC-1:0]   change_latch;
	logic [NSRC-1:0]   next_change_latch;
	logic              latch_clear;
	logic              rd_latch;
	logic              in_hole;
	logic [DATA_W-1:0] next_rdata;

	// Write side goes to both set/clear registers through the interface
	assign bus.wr    = REG_WR;
	assign bus.addr  = REG_ADDR;
	assign bus.wdata = REG_WDATA;

	// Falling-edge enables; reset value turns every source on
	pves_rsc_reg #(
		.BASE      (ADDR_FALL_EN),
		.RESET_VAL (FALL_EN_RESET)
	) u_fall_en (
		.clk   (SYS_CLK),
		.nrst  (NRST),
		.bus   (bus),
		.value (falling_edge_enable)
	);

	// Test byte is read back only, nothing else looks at it
	pves_rsc_reg #(
		.BASE      (ADDR_TEST),
		.RESET_VAL (TEST_RESET)
	) u_test_byte (
		.clk   (SYS_CLK),
		.nrst  (NRST),
		.bus   (bus),
		.value (test_byte)
	);

	// Source vector in the shared bit order
	always_comb begin
		source_level                   = LEVEL_RESET;
		source_level[BIT_SESSION_OVER] = SESSION_OVER_LEVEL;
		source_level[BIT_SESSION_OK]   = SESSION_OK_LEVEL;
		source_level[BIT_BUS_POWER_OK] = BUS_POWER_OK_LEVEL;
		source_level[BIT_DETACH]       = DOWNSTREAM_DETACH_FLAG;
	end

	// Previous levels; zero at reset so release never fakes a fall
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			prev_level <= LEVEL_RESET;
		end else begin
			prev_level <= source_level;
		end
	end

	// One-to-zero transition gated by its enable bit
	assign fall_en    = falling_edge_enable[NSRC-1:0];
	assign fall_event = prev_level & ~source_level & fall_en;

	// Latch clears on its own read or on low power
	assign rd_latch    = REG_RD && (REG_ADDR == ADDR_LATCH);
	assign latch_clear = rd_latch || LOW_POWER;

	// A fall in the clearing cycle survives, so no event is lost
	always_comb begin
		next_change_latch = change_latch;
		if (latch_clear) begin
			next_change_latch = LATCH_RESET;
		end
		next_change_latch = next_change_latch | fall_event;
	end

	// Change latch storage
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			change_latch <= LATCH_RESET;
		end else begin
			change_latch <= next_change_latch;
		end
	end

	// Interrupt stays up while any latched change is pending
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			EVENT_IRQ <= 1'b0;
		end else begin
			EVENT_IRQ <= |next_change_latch;
		end
	end

	// RXCMD request pulse with a snapshot of the levels that caused it
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			RXCMD_REQ    <= 1'b0;
			RXCMD_LEVELS <= LEVEL_RESET;
		end else begin
			RXCMD_REQ <= |fall_event;
			if (|fall_event) begin
				RXCMD_LEVELS <= source_level;
			end
		end
	end

	// Hole decode; reads there give zero and writes hit no register
	assign in_hole = (REG_ADDR >= ADDR_HOLE_LO) && (REG_ADDR <= ADDR_HOLE_HI);

	// Read mux; unmapped addresses and unused status, latch and monitor bits read as zero
	always_comb begin
		next_rdata = READ_ZERO;
		case (REG_ADDR)
			ADDR_FALL_EN, ADDR_FALL_EN_SET, ADDR_FALL_EN_CLR: begin
				next_rdata = falling_edge_enable;
			end
			ADDR_STATUS: begin
				next_rdata = {{(DATA_W-NSRC){1'b0}}, source_level};
			end
			ADDR_LATCH: begin
				next_rdata = {{(DATA_W-NSRC){1'b0}}, change_latch};
			end
			ADDR_MONITOR: begin
				next_rdata = {{(DATA_W-LINE_W){1'b0}}, LINE_STATE};
			end
			ADDR_TEST, ADDR_TEST_SET, ADDR_TEST_CLR: begin
				next_rdata = test_byte;
			end
			default: begin
				next_rdata = READ_ZERO;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= RDATA_RESET;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
		end else begin
			REG_RDATA <= RDATA_RESET;
		end
	end

	// Reset leaves every falling edge reported
	a_enable_reset: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(NRST) |-> falling_edge_enable == FALL_EN_RESET)
		else $error("falling-edge enables not all set after reset");

	// Enabled fall gives an RXCMD pulse next cycle and interrupt
	a_fall_rxcmd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(fall_event != LEVEL_RESET) |=> RXCMD_REQ && EVENT_IRQ
			&& RXCMD_LEVELS == $past(source_level))
		else $error("enabled fall did not raise RXCMD and interrupt");

	// Masked or absent fall sends nothing
	a_quiet_no_rxcmd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(fall_event == LEVEL_RESET) |=> !RXCMD_REQ)
		else $error("RXCMD sent without an enabled fall");

	// Masked detach fall leaves its latch bit alone
	a_mask_blocks: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(prev_level[BIT_DETACH] && !source_level[BIT_DETACH]
			&& !fall_en[BIT_DETACH] && !change_latch[BIT_DETACH])
		|=> !change_latch[BIT_DETACH])
		else $error("masked fall reached the latch");

	// Every enabled fall is latched even when a clear coincides
	a_fall_latched: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(fall_event != LEVEL_RESET) |=> (change_latch & $past(fall_event)) == $past(fall_event))
		else $error("enabled fall not caught in the latch");

	// Latch read returns the bits and then clears them
	a_read_clears: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(rd_latch && fall_event == LEVEL_RESET) |=> change_latch == LATCH_RESET
			&& REG_RDATA == {{(DATA_W-NSRC){1'b0}}, $past(change_latch)})
		else $error("latch read did not return and clear the bits");

	// Low-power entry empties the latch
	a_lowpwr_clears: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(LOW_POWER && fall_event == LEVEL_RESET) |=> change_latch == LATCH_RESET)
		else $error("low-power mode did not clear the latch");

	// Status read reflects the live levels of the read cycle
	a_status_live: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && REG_ADDR == ADDR_STATUS)
		|=> REG_RDATA == {{(DATA_W-NSRC){1'b0}}, $past(source_level)})
		else $error("status read does not show the source levels");

	// Monitor read reflects the line state
	a_monitor_line: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && REG_ADDR == ADDR_MONITOR)
		|=> REG_RDATA == {{(DATA_W-LINE_W){1'b0}}, $past(LINE_STATE)})
		else $error("monitor read does not show the line state");

	// Test byte clear alias reads back the same byte
	a_test_readback: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && REG_ADDR == ADDR_TEST_CLR) |=> REG_RDATA == $past(test_byte))
		else $error("test byte alias read wrong value");

	// Test byte writes do not disturb the event logic
	a_test_isolated: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && REG_ADDR >= ADDR_TEST && REG_ADDR <= ADDR_TEST_CLR)
		|=> $stable(falling_edge_enable))
		else $error("test byte write changed the enables");

	// Hole reads give zero and hole writes change nothing
	a_hole_read_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && in_hole) |=> REG_RDATA == READ_ZERO)
		else $error("unmapped read returned data");

	a_hole_no_effect: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && in_hole) |=> $stable(falling_edge_enable) && $stable(test_byte))
		else $error("unmapped write changed a register");

	// Read data is zero in any cycle not following a read strobe
	a_rdata_one_cycle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!REG_RD |=> REG_RDATA == RDATA_RESET)
		else $error("read data stood past its cycle");

	// Interrupt level follows the latch contents exactly
	a_irq_tracks_latch: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		EVENT_IRQ == (change_latch != LATCH_RESET))
		else $error("interrupt level differs from the latch");

	// Latch bits appear only from an enabled fall; rises are ignored
	a_latch_no_spurious: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		1'b1 |=> (change_latch & ~$past(change_latch) & ~$past(fall_event)) == LATCH_RESET)
		else $error("latch bit set without an enabled fall");

	// Snapshot of the levels holds between falls
	a_levels_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(fall_event == LEVEL_RESET) |=> $stable(RXCMD_LEVELS))
		else $error("RXCMD levels changed without a fall");

	// Set alias reads back the enable byte
	a_enable_alias_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && REG_ADDR == ADDR_FALL_EN_SET)
		|=> REG_RDATA == $past(falling_edge_enable))
		else $error("enable set alias read wrong value");

	// Clearing with no fall pending drops the interrupt
	a_irq_clears: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(latch_clear && fall_event == LEVEL_RESET) |=> !EVENT_IRQ)
		else $error("interrupt stayed up after the latch was cleared");

	// Writes to the latch address are ignored, only a read or low power clears it
	a_latch_no_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && REG_ADDR == ADDR_LATCH && !latch_clear && fall_event == LEVEL_RESET)
		|=> $stable(change_latch))
		else $error("write to the read-only latch changed it");
endmodule : pves_regs

// ---- bench/pves_link_model.sv ----
// Link-side model that collects RXCMD requests from the event block.
// Assumes the request is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module pves_link_model (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      req,
	input  wire logic [pves_pkg::NSRC-1:0] levels
);
	int                      pulses;
	logic [pves_pkg::NSRC-1:0] last_levels;

	// Count requests; the latch is never read here since RXCMD carries the news
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulses      <= 0;
			last_levels <= 4'h0;
		end else if (req) begin
			pulses      <= pulses + 1;
			last_levels <= levels;
		end
	end
endmodule : pves_link_model

// ---- bench/pves_tb.sv ----
// Self-checking bench for the bus-power event and status registers.
// Assumes pves_pkg, the design and the link model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	import pves_pkg::*;
	logic              SYS_CLK    = 1'b0;
	logic              NRST       = 1'b0;
	logic [ADDR_W-1:0] REG_ADDR   = 6'h00;
	logic [DATA_W-1:0] REG_WDATA  = 8'h00;
	logic              REG_WR     = 1'b0;
	logic              REG_RD     = 1'b0;
	logic [NSRC-1:0]   LEVELS     = 4'h0;
	logic [LINE_W-1:0] LINE_STATE = 2'h0;
	logic              LOW_POWER  = 1'b0;
	logic [DATA_W-1:0] REG_RDATA;
	logic              EVENT_IRQ;
	logic              RXCMD_REQ;
	logic [NSRC-1:0]   RXCMD_LEVELS;
	int                miscompares = 0;
	int                compares    = 0;

	// Free-running 125 MHz clock
	always #4 SYS_CLK = ~SYS_CLK;

	pves_regs DUT (.SYS_CLK(SYS_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.SESSION_OVER_LEVEL(LEVELS[3]), .SESSION_OK_LEVEL(LEVELS[2]),
		.BUS_POWER_OK_LEVEL(LEVELS[1]), .DOWNSTREAM_DETACH_FLAG(LEVELS[0]),
		.LINE_STATE(LINE_STATE), .LOW_POWER(LOW_POWER), .EVENT_IRQ(EVENT_IRQ),
		.RXCMD_REQ(RXCMD_REQ), .RXCMD_LEVELS(RXCMD_LEVELS));

	pves_link_model LINK (.clk(SYS_CLK), .nrst(NRST), .req(RXCMD_REQ),
		.levels(RXCMD_LEVELS));

	// Verdict; also reached from the watchdog
	task automatic final_report;
		$display("TB: compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// One-cycle write; the leading edge wait keeps strobe updates apart
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge SYS_CLK);
		REG_WR    <= 1'b1;
		REG_ADDR  <= a;
		REG_WDATA <= d;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask : wr

	// One-cycle read; data is looked at only in the cycle after the read edge
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge SYS_CLK);
		REG_RD   <= 1'b1;
		REG_ADDR <= a;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1;
		`CHK(REG_RDATA, e)
	endtask : rchk

	// Move the sources, then judge request count, levels, interrupt and latch
	task automatic fall(input logic [NSRC-1:0] v, input int n, input logic [NSRC-1:0] lat);
		int p0;
		p0 = LINK.pulses;
		@(posedge SYS_CLK);
		LEVELS <= v;
		repeat (4) @(posedge SYS_CLK);
		#1;
		`CHK(LINK.pulses - p0, n)
		if (n != 0) `CHK(RXCMD_LEVELS, v)
		if (n != 0) `CHK(LINK.last_levels, v)
		`CHK(EVENT_IRQ, lat != 4'h0)
		rchk(ADDR_LATCH, {4'h0, lat});
	endtask : fall

	task automatic t_reset;
		for (int k = 0; k < 3; k++) begin
			rchk(ADDR_FALL_EN + 6'(k), 8'h1f);
			rchk(ADDR_TEST + 6'(k), 8'h00);
		end
		rchk(ADDR_LATCH, 8'h00);
		rchk(ADDR_MONITOR, 8'h00);
	endtask : t_reset

	// Rising levels first, then two falls, so the latch catches them
	task automatic t_status;
		@(posedge SYS_CLK);
		LEVELS     <= 4'h5;
		LINE_STATE <= 2'h2;
		rchk(ADDR_STATUS, 8'h05);
		rchk(ADDR_MONITOR, 8'h02);
		@(posedge SYS_CLK);
		LEVELS     <= 4'ha;
		LINE_STATE <= 2'h1;
		rchk(ADDR_STATUS, 8'h0a);
		rchk(ADDR_MONITOR, 8'h01);
		rchk(ADDR_LATCH, 8'h05);
		@(posedge SYS_CLK);
		LEVELS <= 4'h0;
		rchk(ADDR_LATCH, 8'h0a);
	endtask : t_status

	// Write, set and clear aliases read back through every read address
	task automatic t_alias(input logic [ADDR_W-1:0] b);
		wr(b, 8'h05);
		rchk(b + 6'h02, 8'h05);
		wr(b + 6'h01, 8'h88);
		rchk(b, 8'h8d);
		wr(b + 6'h02, 8'h0c);
		rchk(b + 6'h01, 8'h81);
	endtask : t_alias

	task automatic t_events;
		for (int i = 0; i < NSRC; i++) begin
			fall(4'hf, 0, 4'h0);
			fall(4'hf ^ (4'h1 << i), 1, 4'h1 << i);
		end
		fall(4'hf, 0, 4'h0);
		fall(4'h0, 1, 4'hf);
	endtask : t_events

	task automatic t_mask;
		wr(ADDR_FALL_EN_CLR, 8'h04);
		fall(4'hf, 0, 4'h0);
		fall(4'hb, 0, 4'h0);
		wr(ADDR_FALL_EN_SET, 8'h04);
		rchk(ADDR_FALL_EN, 8'h1f);
	endtask : t_mask

	// A latched fall must vanish once low-power mode is entered
	task automatic t_low_power;
		fall(4'hf, 0, 4'h0);
		@(posedge SYS_CLK);
		LEVELS <= 4'he;
		repeat (3) @(posedge SYS_CLK);
		#1;
		`CHK(EVENT_IRQ, 1'b1)
		@(posedge SYS_CLK);
		LOW_POWER <= 1'b1;
		@(posedge SYS_CLK);
		LOW_POWER <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		#1;
		`CHK(EVENT_IRQ, 1'b0)
		rchk(ADDR_LATCH, 8'h00);
		// A fall in the clearing cycle must still be latched
		@(posedge SYS_CLK);
		LOW_POWER <= 1'b1;
		LEVELS    <= 4'hc;
		@(posedge SYS_CLK);
		LOW_POWER <= 1'b0;
		LEVELS    <= 4'he;
		rchk(ADDR_LATCH, 8'h02);
	endtask : t_low_power

	// Hole and read-only writes must leave every register alone
	task automatic t_hole;
		wr(ADDR_HOLE_LO, 8'hff);
		wr(ADDR_HOLE_HI, 8'hff);
		wr(ADDR_STATUS, 8'hff);
		wr(ADDR_LATCH, 8'hff);
		rchk(ADDR_HOLE_LO, 8'h00);
		rchk(ADDR_HOLE_HI, 8'h00);
		rchk(ADDR_FALL_EN, 8'h1f);
		rchk(ADDR_TEST, 8'h81);
		rchk(ADDR_LATCH, 8'h00);
		rchk(ADDR_STATUS, 8'h0e);
	endtask : t_hole

	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		miscompares++;
		final_report;
	end

	initial begin
		repeat (5) @(posedge SYS_CLK);
		NRST <= 1'b1;
		t_reset;
		t_status;
		t_alias(ADDR_FALL_EN);
		t_alias(ADDR_TEST);
		rchk(ADDR_FALL_EN, 8'h81);
		wr(ADDR_FALL_EN, 8'h1f);
		t_events;
		t_mask;
		t_low_power;
		t_hole;
		// Mid-run reset must bring back the enables and clear the test byte
		wr(ADDR_FALL_EN, 8'h00);
		@(posedge SYS_CLK);
		NRST       <= 1'b0;
		LINE_STATE <= 2'h0;
		repeat (2) @(posedge SYS_CLK);
		NRST <= 1'b1;
		t_reset;
		final_report;
	end
endmodule : testbench
